// ---- logic/tsm_pkg.sv ----
// Purpose: Shared constants and carriers for the time-slot switch memory access block.
// Assumes: One serial highway per side, 128 time slots of 8 bits per frame.
// Notes: Rules that the block and its processor keep.
package tsm_pkg;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_CHA_DATA = 4'h3;
  localparam logic [3:0] REG_CHB_DATA = 4'h4;
  localparam logic [3:0] REG_CHA_RXADDR = 4'h5;
  localparam logic [3:0] REG_CHB_RXADDR = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'hf;
  localparam int BUSY_BIT = 0;
  localparam int RWS_BIT = 7;
  localparam int UD_BIT = 7;
  localparam int SRC_SEL_BIT = 7;
  localparam logic RWS_WRITE = 1'b0;
  localparam logic UD_UP = 1'b0;
  localparam logic UD_DOWN = 1'b1;
  localparam logic SRC_TRUNK = 1'b0;
  localparam logic [6:0] OP_CM_DATA = 7'h48;
  localparam logic [3:0] OP_CM_CODE_WR = 4'h7;
  localparam logic [7:0] OP_CM_CODE_RD = 8'hf0;
  localparam logic [2:0] OP_LOW_ZERO = 3'h0;
  localparam logic [3:0] MOC_NONE = 4'h0;
  localparam logic [3:0] CODE_PROC_ACCESS = 4'h9;
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;
  localparam logic [1:0] MODE3 = 2'h3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [6:0] TX_LEAD = 7'h02;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } tsm_bus_s;

  typedef struct packed {
    logic [6:0] slot;
    logic [7:0] trunk;
    logic [7:0] sub;
  } tsm_rx_s;

  typedef struct packed {
    logic [6:0] slot;
    logic active;
    logic [7:0] data;
  } tsm_tx_s;
endpackage

// ---- logic/tsm_switch_access.sv ----
// Purpose: Processor register bank with indirect switching memory access and two
//          synchronous byte capture channels.
// Assumes: Bus pins are asynchronous to clock; serial lines and frame sync are
//          timed by link_clk; mode inputs come from logic on clock.
// Notes: Received slot bytes cross to clock through a toggle handshake and a FIFO.
`timescale 1ns/100ps

module tsm_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // tsm_fifo

module tsm_switch_access (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic [1:0] trunk_mode,
  input wire logic [1:0] sub_mode,
  input wire logic link_clk,
  input wire logic link_fsync,
  input wire logic trunk_rx,
  input wire logic sub_rx,
  output logic sub_tx,
  output logic sub_tx_oe
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } tsm_op_e;

  // ---------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------
  // Both functions fold the mode-dependent fields into {port, slot},
  // which is also the serial slot number on the single highway.
  function automatic logic [6:0] dm_index(input logic [1:0] mode, input logic [6:0] a);
    logic [6:0] r;
    r = a;
    unique case (mode)
      tsm_pkg::MODE0: r = {a[2:1], a[6:3], a[0]};
      tsm_pkg::MODE1, tsm_pkg::MODE3: r = {a[2], a[6:3], a[1:0]};
      tsm_pkg::MODE2: r = a;
    endcase
    return r;
  endfunction

  function automatic logic [6:0] cm_index(input logic [1:0] mode, input logic [6:0] a);
    logic [6:0] r;
    r = a;
    unique case (mode)
      tsm_pkg::MODE0: r = {a[2:1], a[6:3], a[0]};
      tsm_pkg::MODE1: r = {a[1], a[6:3], a[2], a[0]};
      tsm_pkg::MODE2: r = a;
      tsm_pkg::MODE3: r = {a[3:1], a[6:4], a[0]};
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Processor pins
  // ---------------------------------------------------------------
  tsm_pkg::tsm_bus_s bus_s1;
  tsm_pkg::tsm_bus_s bus_s2;
  tsm_pkg::tsm_bus_s bus_s3;
  logic wr_pulse;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_s1 <= '1;
      bus_s2 <= '1;
      bus_s3 <= '1;
    end else begin
      bus_s1 <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
    end
  end

  // Writes act on the rising write strobe, when address and data have
  // been stable for the whole strobe.
  assign wr_pulse = bus_s2.wr_n && !bus_s3.wr_n && !bus_s3.cs_n;

  // ---------------------------------------------------------------
  // Registers and memories
  // ---------------------------------------------------------------
  logic [7:0] cmd;
  logic [7:0] maddr;
  logic [7:0] mdata;
  logic [7:0] cha_data;
  logic [7:0] chb_data;
  logic [7:0] cha_rxaddr;
  logic [7:0] chb_rxaddr;
  tsm_op_e state;
  logic busy;
  logic [3:0] cm_code [256];
  logic [7:0] cm_data [256];
  logic [7:0] dm_mem [256];
  logic [7:0] cm_loc;
  logic [7:0] dm_loc;
  logic exec;
  logic op_rd;
  logic op_cm_data;
  logic op_code_wr;
  logic op_code_rd;
  logic op_dm_data;

  assign busy = state != ST_IDLE;
  assign exec = state == ST_EXEC;
  assign op_rd = cmd[tsm_pkg::RWS_BIT] != tsm_pkg::RWS_WRITE;
  assign op_cm_data = cmd[6:0] == tsm_pkg::OP_CM_DATA;
  assign op_code_wr = cmd[7:4] == tsm_pkg::OP_CM_CODE_WR;
  assign op_code_rd = cmd == tsm_pkg::OP_CM_CODE_RD;
  assign op_dm_data = !op_cm_data && !op_code_wr && !op_code_rd
    && cmd[2:0] == tsm_pkg::OP_LOW_ZERO && cmd[6:3] != tsm_pkg::MOC_NONE;
  assign cm_loc = {maddr[tsm_pkg::UD_BIT], cm_index(sub_mode, maddr[6:0])};
  assign dm_loc = {maddr[tsm_pkg::UD_BIT], dm_index(trunk_mode, maddr[6:0])};

  // A command written while busy is dropped; software must wait.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cmd <= tsm_pkg::REG_RESET;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (wr_pulse && bus_s3.addr == tsm_pkg::REG_CMD) begin
            cmd <= bus_s3.data;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      maddr <= tsm_pkg::REG_RESET;
      cha_rxaddr <= tsm_pkg::REG_RESET;
      chb_rxaddr <= tsm_pkg::REG_RESET;
    end else if (wr_pulse) begin
      if (bus_s3.addr == tsm_pkg::REG_ADDR) begin
        maddr <= bus_s3.data;
      end
      if (bus_s3.addr == tsm_pkg::REG_CHA_RXADDR) begin
        cha_rxaddr <= bus_s3.data;
      end
      if (bus_s3.addr == tsm_pkg::REG_CHB_RXADDR) begin
        chb_rxaddr <= bus_s3.data;
      end
    end
  end

  // The memory operation result wins over a processor write in the same
  // cycle; that only happens when software ignores the busy flag.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mdata <= tsm_pkg::REG_RESET;
    end else if (exec && op_rd && op_cm_data) begin
      mdata <= cm_data[cm_loc];
    end else if (exec && op_code_rd) begin
      mdata <= {4'h0, cm_code[cm_loc]};
    end else if (exec && op_rd && op_dm_data) begin
      mdata <= dm_mem[dm_loc];
    end else if (wr_pulse && bus_s3.addr == tsm_pkg::REG_DATA) begin
      mdata <= bus_s3.data;
    end
  end

  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  logic lrst_s1;
  logic lrst;
  logic fsync_q;
  logic trunk_q;
  logic sub_q;
  logic [9:0] bit_cnt;
  logic [9:0] pos;
  logic [7:0] trunk_sh;
  logic [7:0] sub_sh;
  logic [7:0] tx_sh;
  logic req_tgl;
  tsm_pkg::tsm_rx_s link_word;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;
  tsm_pkg::tsm_tx_s tx_hold;
  tsm_pkg::tsm_tx_s tx_back;
  logic ack_tgl;
  logic [6:0] next_slot;
  logic slot_end;

  assign pos = fsync_q ? 10'h000 : bit_cnt;
  assign slot_end = pos[2:0] == tsm_pkg::LAST_BIT;
  assign next_slot = 7'(pos[9:3] + 1'b1);
  assign sub_tx = tx_sh[7];

  always_ff @(posedge link_clk) begin
    lrst_s1 <= sys_rst;
    lrst <= lrst_s1;
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      fsync_q <= 1'b0;
      trunk_q <= 1'b0;
      sub_q <= 1'b0;
      bit_cnt <= 10'h000;
      trunk_sh <= tsm_pkg::REG_RESET;
      sub_sh <= tsm_pkg::REG_RESET;
    end else begin
      fsync_q <= link_fsync;
      trunk_q <= trunk_rx;
      sub_q <= sub_rx;
      bit_cnt <= 10'(pos + 1'b1);
      trunk_sh <= {trunk_sh[6:0], trunk_q};
      sub_sh <= {sub_sh[6:0], sub_q};
    end
  end

  // A slot byte is offered only if the previous one was taken; a stalled
  // clock side loses bytes rather than mixing slots.
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      req_tgl <= 1'b0;
      link_word <= '0;
    end else if (slot_end && req_tgl == ack_s2) begin
      link_word <= {pos[9:3], trunk_sh[6:0], trunk_q, sub_sh[6:0], sub_q};
      req_tgl <= !req_tgl;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      tx_hold <= '0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ack_s2 != ack_s3) begin
        tx_hold <= tx_back;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      tx_sh <= tsm_pkg::IDLE_BYTE;
      sub_tx_oe <= 1'b0;
    end else if (slot_end) begin
      if (tx_hold.slot == next_slot && tx_hold.active) begin
        tx_sh <= tx_hold.data;
        sub_tx_oe <= 1'b1;
      end else begin
        tx_sh <= tsm_pkg::IDLE_BYTE;
        sub_tx_oe <= 1'b0;
      end
    end else begin
      tx_sh <= {tx_sh[6:0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // Crossing into clock and slot processing
  // ---------------------------------------------------------------
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic pend;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  tsm_pkg::tsm_rx_s fifo_out;
  logic [6:0] tx_slot;
  logic [7:0] up_loc;
  logic cha_hit;
  logic chb_hit;

  assign tx_slot = 7'(link_word.slot + tsm_pkg::TX_LEAD);
  // Slot processing waits for an idle engine so memory writes never collide.
  assign fifo_pop = fifo_out_valid && !busy;
  assign up_loc = {tsm_pkg::UD_UP, fifo_out.slot};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      pend <= 1'b0;
      ack_tgl <= 1'b0;
      tx_back <= '0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 != req_s3) begin
        pend <= 1'b1;
      end else if (pend && fifo_in_ready) begin
        pend <= 1'b0;
        ack_tgl <= !ack_tgl;
        tx_back.slot <= tx_slot;
        tx_back.active <= cm_code[{tsm_pkg::UD_DOWN, tx_slot}]
          == tsm_pkg::CODE_PROC_ACCESS;
        tx_back.data <= cm_data[{tsm_pkg::UD_DOWN, tx_slot}];
      end
    end
  end

  tsm_fifo #(
    .WIDTH($bits(tsm_pkg::tsm_rx_s)),
    .DEPTH(tsm_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(pend),
    .in_ready(fifo_in_ready),
    .in_data(link_word),
    .out_valid(fifo_out_valid),
    .out_ready(!busy),
    .out_data(fifo_out)
  );

  always_comb begin
    cha_hit = (cha_rxaddr[tsm_pkg::SRC_SEL_BIT] == tsm_pkg::SRC_TRUNK)
      ? dm_index(trunk_mode, cha_rxaddr[6:0]) == fifo_out.slot
      : cm_index(sub_mode, cha_rxaddr[6:0]) == fifo_out.slot;
    chb_hit = (chb_rxaddr[tsm_pkg::SRC_SEL_BIT] == tsm_pkg::SRC_TRUNK)
      ? dm_index(trunk_mode, chb_rxaddr[6:0]) == fifo_out.slot
      : cm_index(sub_mode, chb_rxaddr[6:0]) == fifo_out.slot;
  end

  // A captured slot byte wins over a processor write to the same register.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cha_data <= tsm_pkg::REG_RESET;
    end else if (fifo_pop && cha_hit) begin
      cha_data <= cha_rxaddr[tsm_pkg::SRC_SEL_BIT] == tsm_pkg::SRC_TRUNK
        ? fifo_out.trunk : fifo_out.sub;
    end else if (wr_pulse && bus_s3.addr == tsm_pkg::REG_CHA_DATA) begin
      cha_data <= bus_s3.data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chb_data <= tsm_pkg::REG_RESET;
    end else if (fifo_pop && chb_hit) begin
      chb_data <= chb_rxaddr[tsm_pkg::SRC_SEL_BIT] == tsm_pkg::SRC_TRUNK
        ? fifo_out.trunk : fifo_out.sub;
    end else if (wr_pulse && bus_s3.addr == tsm_pkg::REG_CHB_DATA) begin
      chb_data <= bus_s3.data;
    end
  end

  // ---------------------------------------------------------------
  // Memory arrays
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 256; i++) begin
        cm_code[i] <= tsm_pkg::CODE_UNASSIGNED;
      end
    end else if (exec && op_code_wr) begin
      cm_code[cm_loc] <= cmd[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (exec && op_code_wr) begin
      cm_data[cm_loc] <= mdata;
    end else if (exec && !op_rd && op_cm_data) begin
      cm_data[cm_loc] <= mdata;
    end else if (fifo_pop && cm_code[up_loc] == tsm_pkg::CODE_PROC_ACCESS) begin
      cm_data[up_loc] <= fifo_out.sub;
    end
  end

  always_ff @(posedge clock) begin
    if (exec && !op_rd && op_dm_data) begin
      dm_mem[dm_loc] <= mdata;
    end else if (fifo_pop) begin
      dm_mem[{tsm_pkg::UD_DOWN, fifo_out.slot}] <= fifo_out.trunk;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_data_oe <= 1'b0;
      bus_data_out <= tsm_pkg::REG_RESET;
    end else begin
      bus_data_oe <= !bus_s2.cs_n && !bus_s2.rd_n;
      unique case (bus_s2.addr)
        tsm_pkg::REG_CMD: bus_data_out <= cmd;
        tsm_pkg::REG_ADDR: bus_data_out <= maddr;
        tsm_pkg::REG_DATA: bus_data_out <= mdata;
        tsm_pkg::REG_CHA_DATA: bus_data_out <= cha_data;
        tsm_pkg::REG_CHB_DATA: bus_data_out <= chb_data;
        tsm_pkg::REG_CHA_RXADDR: bus_data_out <= cha_rxaddr;
        tsm_pkg::REG_CHB_RXADDR: bus_data_out <= chb_rxaddr;
        tsm_pkg::REG_STATUS: bus_data_out <= 8'(busy) << tsm_pkg::BUSY_BIT;
        default: bus_data_out <= tsm_pkg::REG_RESET;
      endcase
    end
  end
endmodule // tsm_switch_access

// ---- tb/tsm_link_model.sv ----
// Purpose: Serial highway partner: frame start, receive lines, transmit capture.
// Assumes: Trunk slot s carries {1, s}; subscriber slot s carries {s, 0}.
// Notes: Lines change just after the rising link edge that the block samples.
`timescale 1ns/100ps
module tsm_link_model (
  input wire logic link_clk,
  input wire logic sub_tx,
  input wire logic sub_tx_oe,
  output logic link_fsync,
  output logic trunk_rx,
  output logic sub_rx
);
  logic [9:0] pos = 10'h000;
  logic [9:0] prev;
  logic [7:0] t_byte;
  logic [7:0] s_byte;
  logic [7:0] tx_byte [128];
  logic [7:0] oe_byte [128];
  always @(posedge link_clk) #1 pos <= pos + 10'h001;
  always_comb begin
    t_byte = {1'b1, pos[9:3]};
    s_byte = {pos[9:3], 1'b0};
    link_fsync = pos == 10'h000;
    trunk_rx = t_byte[3'h7 - pos[2:0]];
    sub_rx = s_byte[3'h7 - pos[2:0]];
  end
  // Between edges the line shows the bit launched at the last rising edge.
  always @(negedge link_clk) begin
    prev = pos - 10'h001;
    tx_byte[prev[9:3]] = {tx_byte[prev[9:3]][6:0], sub_tx};
    oe_byte[prev[9:3]] = {oe_byte[prev[9:3]][6:0], sub_tx_oe};
  end
endmodule // tsm_link_model

// ---- tb/tsm_monitor.sv ----
// Purpose: Port checks of the switch access block.
// Assumes: Bus and link timing as handed over by the designer.
// Notes: Bound to every instance of the block.
`timescale 1ns/100ps
module tsm_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  input wire logic [1:0] trunk_mode,
  input wire logic [1:0] sub_mode,
  input wire logic link_clk,
  input wire logic link_fsync,
  input wire logic trunk_rx,
  input wire logic sub_rx,
  input wire logic sub_tx,
  input wire logic sub_tx_oe
);
  // ----
  // Helpers
  // ----
  // The slot bit count means nothing until a frame start has been seen.
  // An enable launched at a slot boundary is first sampled at bit 1 of that slot.
  logic [2:0] bit_pos;
  logic framed;
  logic rd_on;
  assign rd_on = !bus_cs_n && !bus_rd_n;
  always_ff @(posedge link_clk) begin
    if (sys_rst) begin
      framed <= 1'b0;
      bit_pos <= 3'h0;
    end else if (link_fsync) begin
      framed <= 1'b1;
      bit_pos <= 3'h1;
    end else begin
      bit_pos <= bit_pos + 3'h1;
    end
  end
  sequence rd_held_s;
    rd_on [*4];
  endsequence
  sequence addr_read_s;
    (rd_on && bus_addr == 4'h1) [*5];
  endsequence
  // ----
  // Assertions
  // ----
  bus_reset_a: assert property (@(posedge clock)
    sys_rst |=> !bus_data_oe && bus_data_out == 8'h00)
    else $error("bus outputs not quiet in reset");
  oe_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(bus_data_oe) |-> $past(rd_on, 3))
    else $error("data drive without a read strobe");
  oe_on_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    rd_held_s |-> bus_data_oe)
    else $error("data not driven during a read");
  oe_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
    bus_rd_n [*5] |-> !bus_data_oe)
    else $error("data still driven after the read");
  addr_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    addr_read_s |-> $stable(bus_data_out))
    else $error("address register read changed");
  unmapped_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_on && bus_addr inside {[4'h7:4'he]}) [*4] |-> bus_data_out == 8'h00)
    else $error("unmapped read not zero");
  link_reset_a: assert property (@(posedge link_clk)
    sys_rst [*5] |-> sub_tx && !sub_tx_oe)
    else $error("serial output not idle in reset");
  tx_idle_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !sub_tx_oe |-> sub_tx)
    else $error("serial output not idle outside owned slot");
  oe_slot_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    framed && $changed(sub_tx_oe) |-> bit_pos == 3'h1)
    else $error("serial enable changed inside a slot");
endmodule // tsm_monitor

bind tsm_switch_access tsm_monitor i_mon (.clock(clock), .sys_rst(sys_rst),
  .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr),
  .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
  .trunk_mode(trunk_mode), .sub_mode(sub_mode), .link_clk(link_clk),
  .link_fsync(link_fsync), .trunk_rx(trunk_rx), .sub_rx(sub_rx), .sub_tx(sub_tx),
  .sub_tx_oe(sub_tx_oe));

// ---- tb/tsm_switch_access_tb_top.sv ----
// Purpose: Self-checking bench of the switch access block.
// Assumes: The link partner sends slot-numbered bytes on both highways.
// Notes: Each link phase starts at a frame start so every target slot passes after set-up.
`timescale 1ns/100ps
module tsm_switch_access_tb_top;
  typedef struct packed {
    logic [7:0] addr, wdat, wcmd, rcmd, exp;
  } tsm_row_s;
  logic clock;
  logic link_clk;
  logic sys_rst = 1'b1;
  tsm_pkg::tsm_bus_s bus = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
  logic [7:0] bus_data_out, data_wire, v;
  logic bus_data_oe, link_fsync, trunk_rx, sub_rx, sub_tx, sub_tx_oe;
  logic [1:0] trunk_mode = 2'h2;
  logic [1:0] sub_mode = 2'h2;
  int err_count = 0;
  int total_checks = 0;
  logic [3:0] rst_regs [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'hf};
  tsm_row_s rows [8] = '{
    '{8'h05, 8'h3c, 8'h48, 8'hc8, 8'h3c}, '{8'h85, 8'ha5, 8'h48, 8'hc8, 8'ha5},
    '{8'h05, 8'h00, 8'h00, 8'hc8, 8'h3c}, '{8'h10, 8'h66, 8'h08, 8'h88, 8'h66},
    '{8'h86, 8'h5a, 8'h79, 8'hf0, 8'h09}, '{8'h86, 8'h00, 8'h00, 8'hc8, 8'h5a},
    '{8'h86, 8'hc7, 8'h48, 8'hc8, 8'hc7}, '{8'h87, 8'h11, 8'h70, 8'hf0, 8'h00}};
  // The block's drive wins over the tester's inverted data, so the wire follows the block while bus_data_oe is high.
  assign data_wire = bus_data_oe ? bus_data_out : bus.data;
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #17;
    forever #32 link_clk = ~link_clk;
  end
  tsm_switch_access i_dut (.clock(clock), .sys_rst(sys_rst), .bus_cs_n(bus.cs_n),
    .bus_rd_n(bus.rd_n), .bus_wr_n(bus.wr_n), .bus_addr(bus.addr), .bus_data_in(data_wire),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .trunk_mode(trunk_mode),
    .sub_mode(sub_mode), .link_clk(link_clk), .link_fsync(link_fsync), .trunk_rx(trunk_rx),
    .sub_rx(sub_rx), .sub_tx(sub_tx), .sub_tx_oe(sub_tx_oe));
  tsm_link_model i_link (.link_clk(link_clk), .sub_tx(sub_tx), .sub_tx_oe(sub_tx_oe),
    .link_fsync(link_fsync), .trunk_rx(trunk_rx), .sub_rx(sub_rx));
  // ----
  // Tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr = a;
    bus.data = d;
    bus.cs_n = 1'b0;
    bus.wr_n = 1'b0;
    tick(5);
    bus.wr_n = 1'b1;
    tick(1);
    bus.cs_n = 1'b1;
    tick(6);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus.addr = a;
    bus.data = ~bus.data;
    bus.cs_n = 1'b0;
    bus.rd_n = 1'b0;
    tick(5);
    d = data_wire;
    bus.rd_n = 1'b1;
    tick(1);
    bus.cs_n = 1'b1;
    tick(6);
  endtask
  task automatic idle_wait;
    int n;
    n = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 20) begin
      rd(4'hf, v);
      n++;
    end
    chk("busy flag", {7'h00, v[0]}, 8'h00);
  endtask
  task automatic op(input logic [7:0] c);
    idle_wait();
    wr(4'h0, c);
    idle_wait();
  endtask
  function automatic logic [6:0] t_idx(input logic [1:0] m, input logic [6:0] a);
    case (m)
      2'h0: return {a[2:1], a[6:3], a[0]};
      2'h2: return a;
      default: return {a[2], a[6:3], a[1:0]};
    endcase
  endfunction
  function automatic logic [6:0] s_idx(input logic [1:0] m, input logic [6:0] a);
    case (m)
      2'h0: return {a[2:1], a[6:3], a[0]};
      2'h1: return {a[1], a[6:3], a[2], a[0]};
      2'h2: return a;
      default: return {a[3:1], a[6:4], a[0]};
    endcase
  endfunction
  function automatic logic [7:0] rx_exp(input logic sel, input logic [6:0] a);
    return sel ? {s_idx(sub_mode, a), 1'b0} : {1'b1, t_idx(trunk_mode, a)};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    close_out();
  end
  initial begin
    // Reset spans several link edges so the link side leaves reset too.
    tick(100);
    sys_rst = 1'b0;
    foreach (rst_regs[i]) begin
      rd(rst_regs[i], v);
      chk("reset value", v, 8'h00);
    end
    wr(4'h7, 8'hff);
    rd(4'h7, v);
    chk("unmapped place", v, 8'h00);
    foreach (rows[i]) begin
      wr(4'h1, rows[i].addr);
      rd(4'h1, v);
      chk("address register", v, rows[i].addr);
      if (rows[i].wcmd !== 8'h00) begin
        wr(4'h2, rows[i].wdat);
        op(rows[i].wcmd);
      end
      op(rows[i].rcmd);
      rd(4'h2, v);
      chk("data register", v, rows[i].exp);
    end
    for (int i = 0; i < 4; i++) begin
      trunk_mode = 2'(i);
      sub_mode = 2'(3 - i);
      @(posedge link_fsync);
      tick(1);
      wr(4'h5, {i[0], 7'h56});
      wr(4'h6, {~i[0], 7'h39});
      wr(4'h1, 8'he3);
      wr(4'h2, 8'h1e + 8'(i));
      op(8'h79);
      tick(15000);
      rd(4'h3, v);
      chk("channel a byte", v, rx_exp(i[0], 7'h56));
      rd(4'h4, v);
      chk("channel b byte", v, rx_exp(~i[0], 7'h39));
      chk("owned slot", i_link.tx_byte[s_idx(sub_mode, 7'h63)], 8'h1e + 8'(i));
      chk("owned enable", i_link.oe_byte[s_idx(sub_mode, 7'h63)], 8'hff);
    end
    close_out();
  end
endmodule // tsm_switch_access_tb_top
